/* File: core/ovlirq_flags.sv */
// Purpose: sticky event flags, interrupt mask and request output
// Assumes: event pulses come from logic on the same clock
// Notes:   a new event always wins over a clear in the same cycle
`timescale 1ns/1ps
module ovlirq_flags #(
  parameter int unsigned PLANES = ovlirq_pkg::PLANES,
  parameter int unsigned EVENTS = ovlirq_pkg::EVENTS,
  parameter int unsigned STRIDE = ovlirq_pkg::PLANE_STRIDE,
  parameter int unsigned FIRST = ovlirq_pkg::EVT_FIRST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [PLANES*EVENTS-1:0] evt_i,
  input wire logic [31:0] mask_set_i,
  input wire logic [31:0] mask_clr_i,
  input wire logic [31:0] stat_clr_i,
  output logic [31:0] mask_o,
  output logic [31:0] stat_o,
  output logic irq_o
);

  // ==========================================================
  // elaboration check
  if (EVENTS > STRIDE || FIRST + (PLANES - 1) * STRIDE + EVENTS > 32) begin : g_bad
    $error("event groups do not fit a 32-bit word");
  end

  // ==========================================================
  // event placement
  logic [31:0] set_w;
  logic [31:0] stat_q;
  logic [31:0] mask_q;

  for (genvar p = 0; p < 32; p++) begin : g_bit
    localparam int unsigned REL = (p >= FIRST) ? p - FIRST : 0;
    localparam bit VALID = (p >= FIRST) && (REL % STRIDE < EVENTS) && (REL / STRIDE < PLANES);
    if (VALID) begin : g_on
      assign set_w[p] = evt_i[(REL / STRIDE) * EVENTS + REL % STRIDE];
    end else begin : g_off
      assign set_w[p] = 1'b0;
    end
  end

  // ==========================================================
  // flags and mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= ovlirq_pkg::STAT_RST;
      mask_q <= ovlirq_pkg::MASK_RST;
    end else begin
      stat_q <= (stat_q & ~stat_clr_i) | set_w;
      mask_q <= ((mask_q & ~mask_clr_i) | mask_set_i) & ovlirq_pkg::EVT_BITS;
    end
  end

  assign mask_o = mask_q;
  assign stat_o = stat_q;
  assign irq_o = |(stat_q & mask_q);

endmodule

/* File: core/ovlirq_pkg.sv */
// Purpose: shared constants and types of the overlay DMA interrupt registers
// Assumes: 32-bit classic Wishbone, byte addresses, one clock domain
// Notes:   event bits sit in three groups of five, one group per plane
package ovlirq_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned PLANES = 3;
  localparam int unsigned EVENTS = 5;
  localparam int unsigned PLANE_STRIDE = 8;
  localparam int unsigned EVT_FIRST = 2;

  // ==========================================================
  // register byte addresses
  localparam logic [31:0] OFS_CHAN_EN = 32'hF803_8280;
  localparam logic [31:0] OFS_CHAN_SR = 32'hF803_8288;
  localparam logic [31:0] OFS_IRQ_EN = 32'hF803_828C;
  localparam logic [31:0] OFS_IRQ_DIS = 32'hF803_8290;
  localparam logic [31:0] OFS_IRQ_MASK = 32'hF803_8294;
  localparam logic [31:0] OFS_IRQ_STAT = 32'hF803_8298;
  localparam logic [31:0] OFS_HEAD = 32'hF803_829C;
  localparam logic [31:0] OFS_IRQ_CLR = 32'hF803_82F0;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned BIT_QUEUE = 2;
  localparam int unsigned HEAD_LSB = 2;
  localparam logic [31:0] EVT_BITS = 32'h007C_7C7C;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  localparam logic [29:0] HEAD_RST = 30'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // ==========================================================
  // types
  // xfer_end is the lowest bit of each group
  typedef struct packed {
    logic overflow;
    logic list_end;
    logic head_loaded;
    logic desc_loaded;
    logic xfer_end;
  } ovlirq_evt_t;

  typedef enum logic {
    Q_IDLE = 1'b0,
    Q_PEND = 1'b1
  } ovlirq_q_state_t;

endpackage

/* File: core/ovlirq_regs.sv */
// Purpose: register front end of the overlay layer DMA interrupt logic
// Assumes: classic Wishbone slave, 32-bit data, full byte addresses
// Notes:   every access is answered one cycle after the request
`timescale 1ns/1ps
module ovlirq_regs (
  input wire logic clk_i,
  input wire logic rst_i,

  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,

  // per-plane events from the dma channels
  input ovlirq_pkg::ovlirq_evt_t luma_evt_i,
  input ovlirq_pkg::ovlirq_evt_t chroma_u_evt_i,
  input ovlirq_pkg::ovlirq_evt_t chroma_v_evt_i,

  // descriptor queue handshake
  input wire logic head_queued_i,
  output logic queue_head_request_o,
  output logic [31:0] head_ptr_o,

  // interrupt
  output logic irq_o
);

  // ==========================================================
  // bus request decode
  logic ack_q;
  logic [31:0] rdat_q;

  wire req_w = wb_cyc_i & wb_stb_i;
  // a new request is taken once, the answer follows on the next edge
  wire req_new_w = req_w & ~ack_q;
  // writes act on the edge where the master samples ack
  wire wr_fire_w = req_w & ack_q & wb_we_i;
  wire rd_new_w = req_new_w & ~wb_we_i;

  wire hit_chan_en_w = (wb_adr_i == ovlirq_pkg::OFS_CHAN_EN);
  wire hit_chan_sr_w = (wb_adr_i == ovlirq_pkg::OFS_CHAN_SR);
  wire hit_irq_en_w = (wb_adr_i == ovlirq_pkg::OFS_IRQ_EN);
  wire hit_irq_dis_w = (wb_adr_i == ovlirq_pkg::OFS_IRQ_DIS);
  wire hit_irq_mask_w = (wb_adr_i == ovlirq_pkg::OFS_IRQ_MASK);
  wire hit_irq_stat_w = (wb_adr_i == ovlirq_pkg::OFS_IRQ_STAT);
  wire hit_head_w = (wb_adr_i == ovlirq_pkg::OFS_HEAD);
  wire hit_irq_clr_w = (wb_adr_i == ovlirq_pkg::OFS_IRQ_CLR);

  // ==========================================================
  // byte lanes
  logic [31:0] lane_mask_w;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign lane_mask_w[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  wire [31:0] wdat_w = wb_dat_i & lane_mask_w;

  // ==========================================================
  // write strobes
  wire wr_chan_en_w = wr_fire_w & hit_chan_en_w;
  wire wr_irq_en_w = wr_fire_w & hit_irq_en_w;
  wire wr_irq_dis_w = wr_fire_w & hit_irq_dis_w;
  wire wr_head_w = wr_fire_w & hit_head_w;
  wire wr_irq_clr_w = wr_fire_w & hit_irq_clr_w;

  // enable and disable ports store nothing, they only steer the mask
  // enable write sets mask
  wire [31:0] mask_set_w = wr_irq_en_w ? wdat_w : 32'h0000_0000;
  wire [31:0] mask_clr_w = wr_irq_dis_w ? wdat_w : 32'h0000_0000;

  // ==========================================================
  // event flags
  logic [31:0] mask_w;
  logic [31:0] stat_w;
  logic [31:0] stat_clr_w;
  logic [ovlirq_pkg::PLANES*ovlirq_pkg::EVENTS-1:0] evt_w;

  // each plane group is xfer_end, desc_loaded, head_loaded,
  // list_end, overflow from its lowest bit upward
  // luma group at bit 2
  // U/UV in the middle, V on top
  assign evt_w = {chroma_v_evt_i, chroma_u_evt_i, luma_evt_i};

  // read takes the flags it returns
  assign stat_clr_w = (rd_new_w & hit_irq_stat_w ? stat_w : 32'h0000_0000)
                    | (wr_irq_clr_w ? wdat_w : 32'h0000_0000);

  ovlirq_flags #(
    .PLANES(ovlirq_pkg::PLANES),
    .EVENTS(ovlirq_pkg::EVENTS),
    .STRIDE(ovlirq_pkg::PLANE_STRIDE),
    .FIRST(ovlirq_pkg::EVT_FIRST)
  ) u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .evt_i(evt_w),
    .mask_set_i(mask_set_w),
    .mask_clr_i(mask_clr_w),
    .stat_clr_i(stat_clr_w),
    .mask_o(mask_w),
    .stat_o(stat_w),
    .irq_o(irq_o)
  );

  // ==========================================================
  // head pointer
  logic [29:0] head_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_q <= ovlirq_pkg::HEAD_RST;
    end else if (wr_head_w) begin
      head_q <= (head_q & ~lane_mask_w[31:ovlirq_pkg::HEAD_LSB])
              | wdat_w[31:ovlirq_pkg::HEAD_LSB];
    end
  end

  wire [31:0] head_word_w = {head_q, 2'b00};

  assign head_ptr_o = head_word_w;

  // ==========================================================
  // add-to-queue request
  ovlirq_pkg::ovlirq_q_state_t q_state_q;
  ovlirq_pkg::ovlirq_q_state_t q_state_d;

  wire queue_req_w = wr_chan_en_w & wdat_w[ovlirq_pkg::BIT_QUEUE];

  always_comb begin
    q_state_d = q_state_q;
    unique case (q_state_q)
      ovlirq_pkg::Q_IDLE: begin
        if (queue_req_w) begin
          q_state_d = ovlirq_pkg::Q_PEND;
        end
      end
      ovlirq_pkg::Q_PEND: begin
        // a fresh request in the same cycle keeps it pending
        if (head_queued_i && !queue_req_w) begin
          q_state_d = ovlirq_pkg::Q_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_state_q <= ovlirq_pkg::Q_IDLE;
    end else begin
      q_state_q <= q_state_d;
    end
  end

  wire queue_pend_w = (q_state_q == ovlirq_pkg::Q_PEND);

  assign queue_head_request_o = queue_pend_w;

  // ==========================================================
  // read data selection
  logic [31:0] chan_sr_w;

  always_comb begin
    chan_sr_w = 32'h0000_0000;
    chan_sr_w[ovlirq_pkg::BIT_QUEUE] = queue_pend_w;
  end

  // write-only and unmapped addresses read as zero
  // mask readout
  wire [31:0] rd_mask_w = hit_irq_mask_w ? mask_w : ovlirq_pkg::RD_UNMAPPED;
  wire [31:0] rd_stat_w = hit_irq_stat_w ? stat_w : ovlirq_pkg::RD_UNMAPPED;
  wire [31:0] rd_head_w = hit_head_w ? head_word_w : ovlirq_pkg::RD_UNMAPPED;
  wire [31:0] rd_chan_w = hit_chan_sr_w ? chan_sr_w : ovlirq_pkg::RD_UNMAPPED;

  wire [31:0] rd_mux_w = rd_mask_w | rd_stat_w | rd_head_w | rd_chan_w;

  // ==========================================================
  // answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_new_w;
    end
  end

  // status is sampled on the same edge that clears it, so no event is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (rd_new_w) begin
      rdat_q <= rd_mux_w;
    end else if (!req_w) begin
      rdat_q <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule

/* File: test/ovlirq_regs_chk.sv */
// Purpose: port-level checks on the overlay interrupt registers
// Assumes: bound to ovlirq_regs, one clock domain
// Notes:   mask state is unseen, so irq edges are tied to bus or event causes
`timescale 1ns/1ps
module ovlirq_regs_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input ovlirq_pkg::ovlirq_evt_t luma_evt_i,
  input ovlirq_pkg::ovlirq_evt_t chroma_u_evt_i,
  input ovlirq_pkg::ovlirq_evt_t chroma_v_evt_i,
  input wire logic head_queued_i,
  input wire logic queue_head_request_o,
  input wire logic [31:0] head_ptr_o,
  input wire logic irq_o
);
  // ==========
  // helpers
  wire logic wr_ack = wb_ack_o && wb_we_i;
  wire logic any_evt = |{luma_evt_i, chroma_u_evt_i, chroma_v_evt_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // properties
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  irq_rise_a: assert property ($rose(irq_o) |-> $past(any_evt) || $past(wr_ack))
    else $error("irq rose without event or write");
  irq_fall_a: assert property ($fell(irq_o) |-> wb_ack_o || $past(wr_ack))
    else $error("irq fell without read or write");
  read_bits_a: assert property (
    wb_ack_o && !wb_we_i && (wb_adr_i == ovlirq_pkg::OFS_IRQ_MASK
    || wb_adr_i == ovlirq_pkg::OFS_IRQ_STAT) |-> (wb_dat_o & ~ovlirq_pkg::EVT_BITS) == 0)
    else $error("readout outside event bits");
  queue_set_a: assert property (
    wr_ack && wb_adr_i == ovlirq_pkg::OFS_CHAN_EN && wb_sel_i[0]
    && wb_dat_i[2] |=> queue_head_request_o)
    else $error("queue request not raised");
  queue_done_a: assert property (
    queue_head_request_o && head_queued_i && !wr_ack |=> !queue_head_request_o)
    else $error("queue request not cleared");
  head_write_a: assert property (
    wr_ack && wb_adr_i == ovlirq_pkg::OFS_HEAD && wb_sel_i == 4'hF
    |=> head_ptr_o == ($past(wb_dat_i) & 32'hFFFF_FFFC))
    else $error("head pointer write wrong");
  head_hold_a: assert property (!wr_ack |=> $stable(head_ptr_o))
    else $error("head pointer changed without write");
endmodule

/* File: test/ovlirq_regs_tb_top.sv */
// Purpose: self-checking bench for the overlay interrupt registers
// Assumes: classic Wishbone master, one request at a time
// Notes:   events are one-cycle pulses driven at the rising edge, held longer only in t_clear
`timescale 1ns/1ps
module ovlirq_regs_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, hq = 1'b0;
  logic [31:0] adr = 32'h0, dat = 32'h0, q;
  logic [3:0] sel = 4'hF;
  logic [14:0] ev = 15'h0;
  int fail_count = 0, cmp_count = 0;
  wire logic ack, irq, qreq;
  wire logic [31:0] rd, hptr;
  always #5 clk_i = ~clk_i;
  ovlirq_regs ovlirq_regs_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .luma_evt_i(ev[4:0]), .chroma_u_evt_i(ev[9:5]), .chroma_v_evt_i(ev[14:10]),
    .head_queued_i(hq), .queue_head_request_o(qreq), .head_ptr_o(hptr), .irq_o(irq));
  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack", 32'h1, {31'h0, ack});
  endtask
  task automatic pulse(input logic [14:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 15'h0;
    @(posedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    chk("irq", 32'h0, {31'h0, irq});
    chk("queue", 32'h0, {31'h0, qreq});
    chk("head pin", 32'h0, hptr);
    wb(1'b0, ovlirq_pkg::OFS_IRQ_MASK, 32'h0);
    chk("mask", ovlirq_pkg::MASK_RST, q);
    wb(1'b0, ovlirq_pkg::OFS_IRQ_STAT, 32'h0);
    chk("status", ovlirq_pkg::STAT_RST, q);
    wb(1'b0, ovlirq_pkg::OFS_HEAD, 32'h0);
    chk("head", 32'h0, q);
    wb(1'b0, 32'hF803_8300, 32'h0);
    chk("unmapped", ovlirq_pkg::RD_UNMAPPED, q);
  endtask
  task automatic t_events();
    for (int p = 0; p < 3; p++) begin
      for (int e = 0; e < 5; e++) begin
        pulse(15'h1 << (5 * p + e));
        chk("irq", 32'h0, {31'h0, irq});
        wb(1'b0, ovlirq_pkg::OFS_IRQ_STAT, 32'h0);
        chk("status", 32'h1 << (8 * p + e + 2), q);
        wb(1'b0, ovlirq_pkg::OFS_IRQ_STAT, 32'h0);
        chk("status", 32'h0, q);
      end
    end
  endtask
  task automatic t_mask();
    wb(1'b1, ovlirq_pkg::OFS_IRQ_EN, 32'hFFFF_FFFF);
    wb(1'b0, ovlirq_pkg::OFS_IRQ_MASK, 32'h0);
    chk("mask", ovlirq_pkg::EVT_BITS, q);
    wb(1'b1, ovlirq_pkg::OFS_IRQ_DIS, 32'h0040_0404);
    wb(1'b1, ovlirq_pkg::OFS_IRQ_DIS, 32'h0);
    wb(1'b0, ovlirq_pkg::OFS_IRQ_MASK, 32'h0);
    chk("mask", ovlirq_pkg::EVT_BITS & ~32'h0040_0404, q);
  endtask
  task automatic t_irq();
    pulse(15'h10);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, ovlirq_pkg::OFS_IRQ_STAT, 32'h0);
    wb(1'b1, ovlirq_pkg::OFS_IRQ_DIS, 32'h40);
    @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq});
    wb(1'b1, ovlirq_pkg::OFS_IRQ_EN, 32'h40);
    @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b0, ovlirq_pkg::OFS_IRQ_STAT, 32'h0);
    chk("status", 32'h40, q);
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  // the event is held high across a clear write and a status read: set must win
  task automatic t_clear();
    pulse(15'h1);
    wb(1'b1, ovlirq_pkg::OFS_IRQ_CLR, 32'h4);
    wb(1'b0, ovlirq_pkg::OFS_IRQ_STAT, 32'h0);
    chk("clear", 32'h0, q);
    @(posedge clk_i);
    ev <= 15'h1;
    wb(1'b1, ovlirq_pkg::OFS_IRQ_CLR, 32'h4);
    wb(1'b0, ovlirq_pkg::OFS_IRQ_STAT, 32'h0);
    ev <= 15'h0;
    chk("set wins", 32'h4, q);
    wb(1'b0, ovlirq_pkg::OFS_IRQ_STAT, 32'h0);
    chk("set wins", 32'h4, q);
    wb(1'b0, ovlirq_pkg::OFS_IRQ_STAT, 32'h0);
    chk("status", 32'h0, q);
  endtask
  task automatic t_head_queue();
    wb(1'b1, ovlirq_pkg::OFS_HEAD, 32'hFFFF_FFFF);
    wb(1'b0, ovlirq_pkg::OFS_HEAD, 32'h0);
    chk("head", 32'hFFFF_FFFC, q);
    chk("head pin", 32'hFFFF_FFFC, hptr);
    wb(1'b1, ovlirq_pkg::OFS_HEAD, 32'h1234_5678, 4'h3);
    wb(1'b0, ovlirq_pkg::OFS_HEAD, 32'h0);
    chk("head lanes", 32'hFFFF_5678, q);
    wb(1'b1, ovlirq_pkg::OFS_CHAN_EN, 32'h4);
    @(posedge clk_i);
    chk("queue", 32'h1, {31'h0, qreq});
    wb(1'b0, ovlirq_pkg::OFS_CHAN_SR, 32'h0);
    chk("queue status", 32'h4, q);
    chk("queue", 32'h1, {31'h0, qreq});
    hq <= 1'b1;
    @(posedge clk_i);
    hq <= 1'b0;
    @(posedge clk_i);
    chk("queue", 32'h0, {31'h0, qreq});
    wb(1'b0, ovlirq_pkg::OFS_CHAN_SR, 32'h0);
    chk("queue status", 32'h0, q);
  endtask
  // reset in mid-run with an irq and a queue request standing
  task automatic t_rerun();
    wb(1'b1, ovlirq_pkg::OFS_CHAN_EN, 32'h4);
    pulse(15'h10);
    chk("irq", 32'h1, {31'h0, irq});
    chk("queue", 32'h1, {31'h0, qreq});
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
  endtask
  // ==========
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_events();
    t_mask();
    t_irq();
    t_clear();
    t_head_queue();
    t_rerun();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
endmodule
bind ovlirq_regs ovlirq_regs_chk ovlirq_regs_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .luma_evt_i, .chroma_u_evt_i,
  .chroma_v_evt_i, .head_queued_i, .queue_head_request_o, .head_ptr_o, .irq_o);
